// File: testbench/ndsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module ndsr_host (
  input wire logic clk_i,
  output var ndsr_pkg::ndsr_req_t req_o
);
  import ndsr_pkg::*;
  // ----
  // host port
  // ----
  initial req_o = '0;
  // one-cycle request; idle cycle after it keeps edges apart
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) req_o <= '{w, !w, a, d};
    @(posedge clk_i) req_o <= '0;
  endtask
  task automatic stop_disc;
    acc(1, 8'h12, 8'h02);
  endtask
endmodule
`default_nettype wire

// File: testbench/ndsr_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ndsr_regs_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic main_node_i,
  input wire ndsr_pkg::ndsr_req_t req_i,
  input wire logic disc_next_i,
  input wire logic [3:0] disc_next_num_i,
  input wire logic [7:0] rdata_o,
  input wire logic disc_active_o,
  input wire logic [3:0] disc_target_o,
  input wire ndsr_pkg::ndsr_level_t tx_level_o,
  input wire logic tx_override_o
);
  import ndsr_pkg::*;
  // ----
  // port checks
  // ----
  wire logic go = ce_i && req_i.wr;
  wire logic rd = ce_i && req_i.rd;
  wire logic trig = go && req_i.addr == 8'h13 && main_node_i;
  wire logic stop = go && req_i.addr == 8'h12 && req_i.wdata[1];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    trig;
  endsequence
  a_start_sets_flag: assert property (s_start |=> disc_active_o)
    else $error("no start");
  a_end_clears_flag: assert property (stop |=> !disc_active_o)
    else $error("still active");
  a_active_stays_high: assert property (disc_active_o && !stop |=> disc_active_o)
    else $error("active dropped");
  a_next_shows_target: assert property (ce_i && disc_active_o && disc_next_i && !trig && !stop
    |=> disc_target_o == $past(disc_next_num_i))
    else $error("target stale");
  a_idle_target_kept: assert property (!disc_active_o && !trig |=> $stable(disc_target_o))
    else $error("target moved");
  a_level_needs_override: assert property (ce_i && !tx_override_o
    |=> tx_level_o == NDSR_LVL_HIGH)
    else $error("level leaked");
  a_status_read_value: assert property (rd && req_i.addr == 8'h2B
    |=> rdata_o == {$past(disc_active_o), 3'h0, $past(disc_target_o)})
    else $error("status read");
  a_unmapped_reads_zero: assert property (rd && req_i.addr == 8'h7F |=> rdata_o == 8'h00)
    else $error("unmapped read");
  a_main_node_zero: assert property (rd && main_node_i && req_i.addr == 8'h29
    |=> rdata_o[5:0] == 6'h00)
    else $error("main node field");
  a_freeze_holds_outputs: assert property (!ce_i |=> $stable(rdata_o) && $stable(disc_active_o)
    && $stable(disc_target_o) && $stable(tx_level_o) && $stable(tx_override_o))
    else $error("state moved while frozen");
endmodule
bind ndsr_regs ndsr_regs_assertions i_chk (.clk_i, .rst_i, .ce_i, .main_node_i, .req_i,
  .disc_next_i, .disc_next_num_i, .rdata_o, .disc_active_o, .disc_target_o, .tx_level_o,
  .tx_override_o);
`default_nettype wire

// File: testbench/ndsr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ndsr_regs_tb;
  import ndsr_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, main_node_i = 0, node_update_i = 0, disc_next_i = 0;
  logic [3:0] disc_next_num_i = 4'h0, disc_target_o;
  logic [7:0] rdata_o;
  logic disc_active_o, tx_override_o;
  ndsr_node_t node_i = '0;
  ndsr_req_t req_i;
  ndsr_level_t tx_level_o;
  int err_total = 0, compares = 0;
  // ----
  // rows: write value, readback, level
  // ----
  logic [17:0] rows [5] = '{{8'h80, 8'h80, 2'h0}, {8'h81, 8'h81, 2'h1}, {8'h82, 8'h82, 2'h2},
    {8'h03, 8'h03, 2'h0}, {8'hFF, 8'h83, 2'h3}};
  ndsr_regs i_dut (.clk_i, .rst_i, .ce_i, .main_node_i, .req_i, .node_i, .node_update_i,
    .disc_next_i, .disc_next_num_i, .rdata_o, .disc_active_o, .disc_target_o, .tx_level_o,
    .tx_override_o);
  ndsr_host i_host (.clk_i, .req_o(req_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_host.acc(0, a, 8'h00);
    @(negedge clk_i) chk(rdata_o, exp);
  endtask
  task automatic final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // generous: the sequence needs under 0.6 us
  initial begin
    #10000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h29, 8'h80);
    $display("end reset");
    foreach (rows[i]) begin
      i_host.acc(1, 8'h2E, rows[i][17:10]);
      rd(8'h2E, rows[i][9:2]);
      chk({6'h0, tx_level_o}, {6'h0, rows[i][1:0]});
      chk({7'h0, tx_override_o}, {7'h0, rows[i][17]});
    end
    $display("end rows");
    @(posedge clk_i);
    node_i <= '{1'b1, 1'b1, 1'b1, 4'h5};
    node_update_i <= 1;
    @(posedge clk_i);
    node_update_i <= 0;
    rd(8'h29, 8'h65);
    i_host.acc(1, 8'h13, 8'h00);
    rd(8'h2B, 8'h00);
    chk({7'h0, disc_active_o}, 8'h00);
    @(posedge clk_i);
    main_node_i <= 1;
    i_host.acc(1, 8'h29, 8'hFF);
    rd(8'h29, 8'h40);
    $display("end node");
    i_host.acc(1, 8'h01, 8'h03);
    i_host.acc(1, 8'h13, 8'h00);
    rd(8'h2B, 8'h83);
    chk({7'h0, disc_active_o}, 8'h01);
    chk({4'h0, disc_target_o}, 8'h03);
    @(posedge clk_i);
    disc_next_num_i <= 4'h9;
    disc_next_i <= 1;
    @(posedge clk_i);
    disc_next_i <= 0;
    rd(8'h2B, 8'h89);
    chk({4'h0, disc_target_o}, 8'h09);
    i_host.stop_disc;
    rd(8'h2B, 8'h09);
    chk({7'h0, disc_active_o}, 8'h00);
    chk({4'h0, disc_target_o}, 8'h09);
    rd(8'h7F, 8'h00);
    $display("end disc");
    @(posedge clk_i);
    ce_i <= 0;
    i_host.acc(1, 8'h2E, 8'h00);
    ce_i <= 1;
    rd(8'h2E, 8'h83);
    chk({6'h0, tx_level_o}, 8'h03);
    $display("end freeze");
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h29, 8'h80);
    rd(8'h2B, 8'h00);
    rd(8'h2E, 8'h00);
    chk({6'h0, tx_level_o}, 8'h00);
    chk({7'h0, tx_override_o}, 8'h00);
    $display("end second reset");
    final_report;
  end
endmodule
`default_nettype wire

// File: verilog/ndsr_ctl_reg.sv
`timescale 1ns/10ps
`default_nettype none
module ndsr_ctl_reg #(
  parameter int        W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         we_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] next_q;
  always_comb begin
    next_q = q_o;
    if (we_i) begin
      next_q = d_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RST;
    end else if (ce_i) begin
      q_o <= next_q;
    end
  end
endmodule
`default_nettype wire

// File: verilog/ndsr_map.svh
`ifndef NDSR_MAP_SVH
`define NDSR_MAP_SVH
`define NDSR_OFS_NODE        8'h29
`define NDSR_OFS_DISC        8'h2B
`define NDSR_OFS_TXCTL       8'h2E
`define NDSR_OFS_TRIGGER     8'h13
`define NDSR_OFS_NODESEL     8'h01
`define NDSR_OFS_BUSCTL      8'h12
`define NDSR_BIT_LAST        7
`define NDSR_BIT_NEXTFINAL   6
`define NDSR_BIT_FOUND       5
`define NDSR_BIT_ACTIVE      7
`define NDSR_BIT_OVREN       7
`define NDSR_BIT_ENDDISC     1
`define NDSR_RST_TXCTL       8'h00
`define NDSR_RST_NODESEL     4'h0
`define NDSR_RST_DEFLEVEL    2'h0
`endif

// File: verilog/ndsr_pkg.sv
`default_nettype none
package ndsr_pkg;
  typedef enum logic [1:0] {
    NDSR_LVL_HIGH = 2'h0,
    NDSR_LVL_RSVD = 2'h1,
    NDSR_LVL_MED  = 2'h2,
    NDSR_LVL_LOW  = 2'h3
  } ndsr_level_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ndsr_req_t;
  typedef struct packed {
    logic       link_found;
    logic       next_final;
    logic       discovered;
    logic [3:0] number;
  } ndsr_node_t;
  typedef enum logic [1:0] {
    NDSR_IDLE = 2'b01,
    NDSR_DISC = 2'b10
  } ndsr_state_t;
endpackage
`default_nettype wire

// File: verilog/ndsr_regs.sv
// Operation
// RULE1 - last bit set at reset, cleared when downstream found
// RULE2 - next-to-final bit set during discovery
// RULE3 - discovered bit set; main node reads zero
// RULE4 - node number in bits 3:0; main zero
// RULE5 - trigger write sets active, copies node select
// RULE6 - end-discovery bit leaves discovery, clears active
// RULE7 - active bit high throughout discovery mode
// RULE8 - discovery field shows current target node
// RULE9 - idle discovery field keeps last node
// RULE10 - level applied only while override enabled
// RULE11 - level codes: high, reserved, medium, low
// RULE12 - status writes ignored, unused bits zero
`timescale 1ns/10ps
`include "ndsr_map.svh"
`default_nettype none
module ndsr_regs (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              main_node_i,
  input  wire ndsr_pkg::ndsr_req_t req_i,
  input  wire ndsr_pkg::ndsr_node_t node_i,
  input  wire logic              node_update_i,
  input  wire logic              disc_next_i,
  input  wire logic [3:0]        disc_next_num_i,
  output var  logic [7:0]        rdata_o,
  output logic                   disc_active_o,
  output var  logic [3:0]        disc_target_o,
  output var  ndsr_pkg::ndsr_level_t tx_level_o,
  output logic                   tx_override_o
);
  import ndsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ndsr_state_t state;
  ndsr_state_t next_state;
  ndsr_node_t  node;
  ndsr_node_t  next_node;
  logic [3:0]  next_target;
  logic [7:0]  txctl;
  logic [3:0]  node_select;
  logic [7:0]  next_rdata;
  ndsr_level_t next_level;
  logic        wr_trig;
  logic        wr_end;
  logic        wr_txctl;
  logic        wr_nodesel;
  logic        sel_trig;
  logic        sel_busctl;
  logic        sel_txctl;
  logic        sel_nodesel;
  logic        rd_take;
  logic [7:0]  next_rdata_out;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // node and discovery status get no write strobe at all, so a
  // stray host write there can never disturb them
  assign sel_trig    = (req_i.addr == `NDSR_OFS_TRIGGER);
  assign sel_busctl  = (req_i.addr == `NDSR_OFS_BUSCTL);
  assign sel_txctl   = (req_i.addr == `NDSR_OFS_TXCTL);
  assign sel_nodesel = (req_i.addr == `NDSR_OFS_NODESEL);

  // trigger only counts in a main node
  assign wr_trig    = req_i.wr && sel_trig && main_node_i; // RULE5
  assign wr_end     = req_i.wr && sel_busctl && req_i.wdata[`NDSR_BIT_ENDDISC]; // RULE6
  assign wr_txctl   = req_i.wr && sel_txctl;
  assign wr_nodesel = req_i.wr && sel_nodesel;
  assign rd_take    = req_i.rd;

  ndsr_ctl_reg #(.W(8), .RST(`NDSR_RST_TXCTL)) u_txctl (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_txctl),
    .d_i   (req_i.wdata),
    .q_o   (txctl)
  );

  ndsr_ctl_reg #(.W(4), .RST(`NDSR_RST_NODESEL)) u_nodesel (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_nodesel),
    .d_i   (req_i.wdata[3:0]),
    .q_o   (node_select)
  );

  // ----------------------------------------------------------------
  // discovery tracking
  // ----------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_target = disc_target_o;
    case (state)
      NDSR_IDLE: begin
        if (wr_trig) begin
          next_state  = NDSR_DISC; // RULE5
          next_target = node_select; // RULE5
        end
      end
      NDSR_DISC: begin
        if (disc_next_i) begin
          next_target = disc_next_num_i; // RULE8
        end
        // end wins over a trigger in the same cycle
        if (wr_end) begin
          next_state = NDSR_IDLE; // RULE6
        end else if (wr_trig) begin
          // a repeat trigger re-aims at the selected node
          next_target = node_select; // RULE5
        end
      end
      default: begin
        next_state = NDSR_IDLE;
      end
    endcase
  end
  // target kept when idle, cleared only by reset
  assign disc_active_o = (state == NDSR_DISC); // RULE7

  // ----------------------------------------------------------------
  // node status
  // ----------------------------------------------------------------
  always_comb begin
    next_node = node;
    if (node_update_i) begin
      next_node = node_i; // RULE2
    end
  end

  // only a reset clears the target, so idle keeps the last node
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= NDSR_IDLE;
      disc_target_o <= 4'h0;
    end else if (ce_i) begin
      state         <= next_state;
      disc_target_o <= next_target; // RULE9
    end
  end

  // all-zero status means no downstream link, so last reads 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      node <= '0; // RULE1
    end else if (ce_i) begin
      node <= next_node;
    end
  end

  // ----------------------------------------------------------------
  // transmitter override
  // ----------------------------------------------------------------
  assign tx_override_o = txctl[`NDSR_BIT_OVREN];
  always_comb begin
    next_level = ndsr_level_t'(`NDSR_RST_DEFLEVEL);
    if (tx_override_o) begin
      next_level = ndsr_level_t'(txctl[1:0]); // RULE10 RULE11
    end
  end

  // registered level lags the control byte by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_level_o <= ndsr_level_t'(`NDSR_RST_DEFLEVEL);
    end else if (ce_i) begin
      tx_level_o <= next_level; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    case (req_i.addr)
      `NDSR_OFS_NODE: begin
        next_rdata[`NDSR_BIT_LAST]      = ~node.link_found; // RULE1
        next_rdata[`NDSR_BIT_NEXTFINAL] = node.next_final; // RULE2
        next_rdata[`NDSR_BIT_FOUND]     = node.discovered & ~main_node_i; // RULE3
        next_rdata[3:0] = main_node_i ? 4'h0 : node.number; // RULE4
      end
      `NDSR_OFS_DISC: begin
        next_rdata[`NDSR_BIT_ACTIVE] = disc_active_o; // RULE7
        next_rdata[3:0]              = disc_target_o; // RULE8
      end
      `NDSR_OFS_TXCTL: begin
        // reserved bits 6:2 stored but read zero
        next_rdata = {txctl[7], 5'h00, txctl[1:0]};
      end
      default: begin
        next_rdata = 8'h00; // RULE12
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // data holds between reads, so a slow host may take it late
  always_comb begin
    next_rdata_out = rdata_o;
    if (rd_take) begin
      next_rdata_out = next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= next_rdata_out;
    end
  end
endmodule
`default_nettype wire
